// >>> config_strap_and_line_fault.sv
`timescale 1ns/10ps
`default_nettype none
module config_strap_and_line_fault
  import strap_fault_pkg::*;
#(
  parameter int GPI_HOLD_CYCLES = GPI_SPACING_CYCLES
) (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       local_ctrl_channel_enable,
  input  wire logic       gpio0_in,
  input  wire logic       gpio1_in,
  input  wire logic       ms_sync_encoding_enable_in,
  input  wire logic       rx_edc_in,
  input  wire logic       tx_es_in,
  input  wire logic       i2c_to_i2c_mode,
  input  wire logic [1:0] neg_wire_fault_code,
  input  wire logic [1:0] pos_wire_fault_code,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_rd,
  input  wire logic       general_input,
  input  wire logic       gpo_link_valid,
  input  wire logic       gpo_link_level,
  output logic [7:0]      reg_rdata,
  output logic            reg_rvalid,
  output logic            gpio0_out,
  output logic            gpio0_oe,
  output logic            gpio1_out,
  output logic            gpio1_oe,
  output logic            ctrl_channel_active,
  output logic            bypass_mode_select,
  output strap_cfg_t      strap_cfg,
  output logic            config_valid,
  output stagger_taps_t   stagger_taps,
  output logic [9:0]      ctrl_rate_limit_kbps,
  output logic            line_fault_flag_n,
  output logic            general_output,
  output logic            gpi_link_valid,
  output logic            gpi_link_level
);

  boot_state_t state_q;
  boot_state_t state_d;
  logic        stagger_disable_q;
  logic [1:0]  gpio_out_q;
  logic [3:0]  fault_code_q;
  logic        line_ok;

  // Boot sequence: one capture cycle after reset release, then run forever
  always_comb begin
    case (state_q)
      ST_RESET:   state_d = ST_CAPTURE;
      ST_CAPTURE: state_d = ST_RUN;
      ST_RUN:     state_d = ST_RUN;
      default:    state_d = ST_RESET;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_q <= ST_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // Straps are sampled in a clocked cycle after release, never under reset
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl_channel_active <= 1'b0;
      bypass_mode_select  <= 1'b0;
      strap_cfg           <= '0;
      config_valid        <= 1'b0;
    end else if (state_q == ST_CAPTURE) begin
      config_valid        <= 1'b1;
      ctrl_channel_active <= local_ctrl_channel_enable;
      if (local_ctrl_channel_enable) begin
        bypass_mode_select <= ms_sync_encoding_enable_in;
        strap_cfg          <= '0;
      end else begin
        bypass_mode_select                <= 1'b0;
        strap_cfg.double_output_select    <= gpio0_in;
        strap_cfg.bus_width_select        <= gpio1_in;
        strap_cfg.sync_encoding_enable    <= ms_sync_encoding_enable_in;
        strap_cfg.error_correction_enable <= rx_edc_in;
        strap_cfg.output_edge_select      <= tx_es_in;
      end
    end
  end

  // Rate limit follows the active channel mode
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl_rate_limit_kbps <= RATE_UART_TO_I2C_KBPS;
    end else if (i2c_to_i2c_mode) begin
      ctrl_rate_limit_kbps <= RATE_I2C_TO_I2C_KBPS;
    end else begin
      ctrl_rate_limit_kbps <= RATE_UART_TO_I2C_KBPS;
    end
  end

  // Writes only land while the channel is live; the strap pins own it otherwise
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      stagger_disable_q <= STAGGER_DISABLE_RESET;
      gpio_out_q        <= GPIO_OUT_RESET;
    end else if (reg_wr && ctrl_channel_active) begin
      if (reg_addr == STAGGER_CTRL_ADDR) begin
        stagger_disable_q <= reg_wdata[STAGGER_DISABLE_BIT];
      end
      if (reg_addr == GPIO_CTRL_ADDR) begin
        gpio_out_q <= {reg_wdata[GPIO1_OUT_BIT], reg_wdata[GPIO0_OUT_BIT]};
      end
    end
  end

  // Open-drain GPIOs pull low only in channel mode; as straps they are inputs
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      gpio0_out <= 1'b0;
      gpio0_oe  <= 1'b0;
      gpio1_out <= 1'b0;
      gpio1_oe  <= 1'b0;
    end else begin
      gpio0_out <= 1'b0;
      gpio1_out <= 1'b0;
      gpio0_oe  <= ctrl_channel_active && !gpio_out_q[0];
      gpio1_oe  <= ctrl_channel_active && !gpio_out_q[1];
    end
  end

  // Delay-line taps; disabled staggering collapses every group to zero
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      stagger_taps <= '0;
    end else if (stagger_disable_q) begin
      stagger_taps <= '0;
    end else begin
      stagger_taps.group0      <= 3'h0;
      stagger_taps.group1      <= STAG_GROUP1_TAPS;
      stagger_taps.group2      <= STAG_GROUP2_TAPS;
      stagger_taps.group3      <= STAG_GROUP3_TAPS;
      stagger_taps.pixel_clock <= STAG_PCLK_TAPS;
    end
  end

  // Fault status tracks the detector every cycle; reads never disturb it
  assign line_ok = wire_is_normal(neg_wire_fault_code) && wire_is_normal(pos_wire_fault_code);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      fault_code_q      <= {WIRE_NORMAL, WIRE_NORMAL};
      line_fault_flag_n <= 1'b1;
    end else begin
      fault_code_q      <= {neg_wire_fault_code, pos_wire_fault_code};
      line_fault_flag_n <= line_ok;
    end
  end

  // Read port answers one cycle after the strobe; unmapped offsets read zero
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      reg_rdata  <= '0;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          STAGGER_CTRL_ADDR: reg_rdata <= {4'h0, stagger_disable_q, 3'h0};
          GPIO_CTRL_ADDR:    reg_rdata <= {4'h0, gpio_out_q[1], gpio1_in, gpio_out_q[0], gpio0_in};
          LINE_FAULT_ADDR:   reg_rdata <= {4'h0, fault_code_q};
          default:           reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // Remote input level arriving from the far end drives the local output
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      general_output <= 1'b0;
    end else if (gpo_link_valid) begin
      general_output <= gpo_link_level;
    end
  end

  gpi_forwarder #(
    .HOLD_CYCLES (GPI_HOLD_CYCLES)
  ) u_gpi_forwarder (
    .clock          (clock),
    .rst_n          (rst_n),
    .general_input  (general_input),
    .gpi_link_valid (gpi_link_valid),
    .gpi_link_level (gpi_link_level)
  );

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_stagger_taps_on: assert property (
    !stagger_disable_q [*2] |-> stagger_taps.group1 == 3'h2 && stagger_taps.group2 == 3'h4
      && stagger_taps.group3 == 3'h6 && stagger_taps.pixel_clock == 3'h3)
    else $error("staggering taps wrong");
  a_stagger_taps_off: assert property (stagger_disable_q [*2] |-> stagger_taps == '0)
    else $error("taps not zero with staggering off");
  a_strap_channel_mode: assert property (
    state_q == ST_CAPTURE |=> ctrl_channel_active == $past(local_ctrl_channel_enable))
    else $error("channel enable strap not captured");
  a_strap_cfg_capture: assert property (
    state_q == ST_CAPTURE && !local_ctrl_channel_enable |=> strap_cfg ==
      {$past(gpio0_in), $past(gpio1_in), $past(ms_sync_encoding_enable_in), $past(rx_edc_in), $past(tx_es_in)})
    else $error("strap inputs not captured");
  a_edge_select: assert property (
    state_q == ST_CAPTURE && !local_ctrl_channel_enable |=> strap_cfg.output_edge_select
      == $past(tx_es_in))
    else $error("edge select not captured");
  a_strap_frozen: assert property (state_q == ST_RUN |=> $stable(strap_cfg))
    else $error("configuration changed after power-up");
  a_fault_flag: assert property (##1 line_fault_flag_n == $past(line_ok))
    else $error("fault flag does not follow detector");
  a_fault_status_read: assert property (
    reg_rd && reg_addr == LINE_FAULT_ADDR |=> reg_rvalid && reg_rdata[7:4] == 4'h0
      && reg_rdata[3:0] == $past(fault_code_q))
    else $error("fault status read wrong");
  a_neg_field: assert property (##1 fault_code_q[3:2] == $past(neg_wire_fault_code))
    else $error("negative wire field wrong");
  a_pos_field: assert property (##1 fault_code_q[1:0] == $past(pos_wire_fault_code))
    else $error("positive wire field wrong");
  a_rate_limit: assert property (
    i2c_to_i2c_mode |=> ctrl_rate_limit_kbps == 10'd400)
    else $error("rate limit wrong in I2C mode");
  a_stagger_default: assert property (
    $rose(config_valid) |-> !stagger_disable_q)
    else $error("staggering not on by default");
  a_fault_read_clean: assert property (
    reg_rd |=> fault_code_q == $past({neg_wire_fault_code, pos_wire_fault_code}))
    else $error("read disturbed fault status");

  c_strap_mode: cover property (state_q == ST_CAPTURE && !local_ctrl_channel_enable);
  c_fault_seen: cover property ($fell(line_fault_flag_n) ##[1:20] $rose(line_fault_flag_n));
  c_stagger_off: cover property (reg_wr && reg_addr == STAGGER_CTRL_ADDR && reg_wdata[3]);
  c_gpi_sent: cover property (gpi_link_valid);

endmodule
`default_nettype wire

// >>> gpi_forwarder.sv
`timescale 1ns/10ps
`default_nettype none
module gpi_forwarder
  import strap_fault_pkg::*;
#(
  parameter int HOLD_CYCLES = GPI_SPACING_CYCLES
) (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic general_input,
  output logic      gpi_link_valid,
  output logic      gpi_link_level
);

  logic        sent_level_q;
  logic [16:0] hold_q;
  logic        pending;

  assign pending = general_input != sent_level_q;

  // Send a change at once unless a previous one is still spacing out
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sent_level_q   <= 1'b0;
      gpi_link_valid <= 1'b0;
      gpi_link_level <= 1'b0;
    end else begin
      gpi_link_valid <= 1'b0;
      if (pending && hold_q == '0) begin
        sent_level_q   <= general_input;
        gpi_link_valid <= 1'b1;
        gpi_link_level <= general_input;
      end
    end
  end

  // Hold-off delays a change until it ends, so a late change still leaves; one undone before then is never sent
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      hold_q <= '0;
    end else if (pending && hold_q == '0) begin
      hold_q <= 17'(HOLD_CYCLES - 1);
    end else if (hold_q != '0) begin
      hold_q <= hold_q - 17'd1;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_send_within_hold: assert property (
    pending && hold_q == '0 |=> gpi_link_valid && gpi_link_level == $past(general_input))
    else $error("input change not forwarded");
  a_hold_spacing: assert property (gpi_link_valid |=> !gpi_link_valid [*2])
    else $error("forwarded changes too close together");

endmodule
`default_nettype wire

// >>> strap_fault_pkg.sv
package strap_fault_pkg;

  // Clock and timing
  localparam int CLK_PERIOD_PS      = 5000;
  localparam int GPI_SPACING_US     = 350;
  localparam int GPI_SPACING_CYCLES = GPI_SPACING_US * 1000000 / CLK_PERIOD_PS;

  // Register offsets on the local control channel
  localparam logic [7:0] STAGGER_CTRL_ADDR = 8'h08;
  localparam logic [7:0] GPIO_CTRL_ADDR    = 8'h0e;
  localparam logic [7:0] LINE_FAULT_ADDR   = 8'h14;

  // Field positions
  localparam int STAGGER_DISABLE_BIT = 3;
  localparam int GPIO1_OUT_BIT       = 3;
  localparam int GPIO1_IN_BIT        = 2;
  localparam int GPIO0_OUT_BIT       = 1;
  localparam int GPIO0_IN_BIT        = 0;

  // Reset values
  localparam logic       STAGGER_DISABLE_RESET = 1'b0;
  localparam logic [1:0] GPIO_OUT_RESET        = 2'h3;

  // Wire fault codes
  localparam logic [1:0] WIRE_SHORT_SUPPLY = 2'h0;
  localparam logic [1:0] WIRE_SHORT_GROUND = 2'h1;
  localparam logic [1:0] WIRE_NORMAL       = 2'h2;
  localparam logic [1:0] WIRE_OPEN         = 2'h3;

  // Stagger delays in picoseconds and the delay-line tap size
  localparam int STAG_TAP_PS    = 250;
  localparam int STAG_GROUP1_PS = 500;
  localparam int STAG_GROUP2_PS = 1000;
  localparam int STAG_GROUP3_PS = 1500;
  localparam int STAG_PCLK_PS   = 750;
  localparam logic [2:0] STAG_GROUP1_TAPS = 3'(STAG_GROUP1_PS / STAG_TAP_PS);
  localparam logic [2:0] STAG_GROUP2_TAPS = 3'(STAG_GROUP2_PS / STAG_TAP_PS);
  localparam logic [2:0] STAG_GROUP3_TAPS = 3'(STAG_GROUP3_PS / STAG_TAP_PS);
  localparam logic [2:0] STAG_PCLK_TAPS   = 3'(STAG_PCLK_PS / STAG_TAP_PS);

  // Control-channel rate limits in kbps
  localparam logic [9:0] RATE_UART_TO_I2C_KBPS = 10'd1000;
  localparam logic [9:0] RATE_I2C_TO_I2C_KBPS  = 10'd400;

  typedef struct packed {
    logic double_output_select;
    logic bus_width_select;
    logic sync_encoding_enable;
    logic error_correction_enable;
    logic output_edge_select;
  } strap_cfg_t;

  typedef struct packed {
    logic [2:0] group0;
    logic [2:0] group1;
    logic [2:0] group2;
    logic [2:0] group3;
    logic [2:0] pixel_clock;
  } stagger_taps_t;

  typedef enum logic [2:0] {
    ST_RESET   = 3'b001,
    ST_CAPTURE = 3'b010,
    ST_RUN     = 3'b100
  } boot_state_t;

  // True when a wire code reports normal operation
  function automatic logic wire_is_normal(input logic [1:0] code);
    return code == WIRE_NORMAL;
  endfunction

endpackage

// >>> testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import strap_fault_pkg::*;
  logic clock = 1'b0, rst_n = 1'b0, lcc_en = 1'b1;
  logic g0 = 1'b0, g1 = 1'b0, ms = 1'b0, edc = 1'b0, es = 1'b0, i2c = 1'b0;
  logic [1:0] ncode = 2'h2, pcode = 2'h2;
  logic gin = 1'b0, gov = 1'b0, gol = 1'b0;
  logic [7:0] addr, wdata, rdata, d;
  logic wr, rd, rvalid, g0out, g0oe, g1out, g1oe, active, bypass, cfg_ok, flag_n;
  logic gout, gpi_v, gpi_l;
  strap_cfg_t cfg;
  stagger_taps_t taps;
  logic [9:0] rate;
  int fail_count = 0, n_compared = 0;
  localparam stagger_taps_t TAPS_ON = {3'h0, STAG_GROUP1_TAPS, STAG_GROUP2_TAPS,
                                       STAG_GROUP3_TAPS, STAG_PCLK_TAPS};

  // 200 MHz clock
  always #2.5 clock = ~clock;

  config_strap_and_line_fault #(.GPI_HOLD_CYCLES(8)) dut (
    .clock(clock), .rst_n(rst_n), .local_ctrl_channel_enable(lcc_en), .gpio0_in(g0),
    .gpio1_in(g1), .ms_sync_encoding_enable_in(ms), .rx_edc_in(edc), .tx_es_in(es), .i2c_to_i2c_mode(i2c),
    .neg_wire_fault_code(ncode), .pos_wire_fault_code(pcode), .reg_addr(addr), .reg_wr(wr),
    .reg_wdata(wdata), .reg_rd(rd), .general_input(gin), .gpo_link_valid(gov),
    .gpo_link_level(gol), .reg_rdata(rdata), .reg_rvalid(rvalid), .gpio0_out(g0out),
    .gpio0_oe(g0oe), .gpio1_out(g1out), .gpio1_oe(g1oe), .ctrl_channel_active(active),
    .bypass_mode_select(bypass), .strap_cfg(cfg), .config_valid(cfg_ok),
    .stagger_taps(taps), .ctrl_rate_limit_kbps(rate), .line_fault_flag_n(flag_n),
    .general_output(gout), .gpi_link_valid(gpi_v), .gpi_link_level(gpi_l));

  uc_model u_uc (.clock(clock), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata),
                 .reg_rd(rd), .reg_rdata(rdata), .reg_rvalid(rvalid));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Power-up: pins are settled before reset so the capture edge sees them steady
  task automatic power_up();
    @(posedge clock);
    #1 rst_n = 1'b0;
    repeat (8) @(posedge clock);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clock);
    #1;
  endtask

  // Strap mode: every input high and low across two patterns, later pin changes ignored
  task automatic strap_mode();
    logic [4:0] p [2] = '{5'b10110, 5'b01001};
    foreach (p[i]) begin
      lcc_en = 1'b0;
      {g0, g1, ms, edc, es} = p[i];
      power_up();
      check(cfg, p[i], "strap cfg");
      check({active, bypass, cfg_ok}, 3'b001, "strap mode");
      check({g0oe, g1oe, g0out, g1out}, 4'h0, "strap pins undriven");
      {g0, g1, ms, edc, es} = ~p[i];
      lcc_en = 1'b1;
      repeat (3) @(posedge clock);
      #1 check(cfg, p[i], "latched cfg");
      check(active, 1'b0, "channel stays off");
      u_uc.wr(STAGGER_CTRL_ADDR, 8'h08);
      repeat (3) @(posedge clock);
      #1 check(taps, TAPS_ON, "write ignored");
    end
    $display("strap_mode done");
  endtask

  // Channel mode with bypass selected, then stagger on, off and on again
  task automatic channel_stagger();
    lcc_en = 1'b1;
    {g0, g1, ms, edc, es} = 5'b11111;
    power_up();
    check({active, bypass, cfg}, {2'b11, 5'h00}, "channel mode");
    check(taps, TAPS_ON, "stagger default");
    u_uc.wr(STAGGER_CTRL_ADDR, 8'h08);
    repeat (3) @(posedge clock);
    #1 check(taps, 15'h0000, "stagger off");
    u_uc.rd(STAGGER_CTRL_ADDR, d);
    check(d & 8'h08, 8'h08, "disable bit");
    u_uc.wr(STAGGER_CTRL_ADDR, 8'h00);
    repeat (3) @(posedge clock);
    #1 check(taps, TAPS_ON, "stagger back");
    u_uc.rd(8'h20, d);
    check(d, 8'h00, "unmapped read");
    // Both open-drain outputs pulled low, then the input levels read back
    check({g0oe, g1oe, g0out, g1out}, 4'h0, "gpio released");
    u_uc.wr(GPIO_CTRL_ADDR, 8'h00);
    repeat (3) @(posedge clock);
    #1 check({g0oe, g1oe, g0out, g1out}, 4'hc, "gpio pulled low");
    u_uc.rd(GPIO_CTRL_ADDR, d);
    check(d, 8'h05, "gpio register");
    u_uc.wr(GPIO_CTRL_ADDR, 8'h0a);
    repeat (3) @(posedge clock);
    #1 check({g0oe, g1oe}, 2'h0, "gpio released again");
    $display("channel_stagger done");
  endtask

  // All sixteen wire code pairs, flag and status, plus a refused write
  task automatic line_fault();
    for (int i = 0; i < 16; i++) begin
      {ncode, pcode} = 4'(i);
      repeat (2) @(posedge clock);
      #1 check(flag_n, (i == 10), "fault flag");
      u_uc.rd(LINE_FAULT_ADDR, d);
      check(d, {4'h0, 4'(i)}, "fault status");
      u_uc.rd(LINE_FAULT_ADDR, d);
      check(d, {4'h0, 4'(i)}, "second read");
    end
    u_uc.wr(LINE_FAULT_ADDR, 8'hff);
    u_uc.rd(LINE_FAULT_ADDR, d);
    check(d, 8'h0f, "read only status");
    {ncode, pcode} = 4'ha;
    repeat (2) @(posedge clock);
    #1 check(flag_n, 1'b1, "flag recovers");
    $display("line_fault done");
  endtask

  // Rate limit per mode and general input forwarding both ways
  task automatic rate_and_gpio();
    int n;
    i2c = 1'b1;
    repeat (3) @(posedge clock);
    #1 check(rate, 10'd400, "i2c rate");
    i2c = 1'b0;
    repeat (3) @(posedge clock);
    #1 check(rate, 10'd1000, "uart rate");
    for (int k = 0; k < 2; k++) begin
      gin = ~gin;
      n = 0;
      while (gpi_v !== 1'b1 && n < 4) begin
        @(posedge clock);
        #1 n++;
      end
      check({gpi_v, gpi_l}, {1'b1, gin}, "gpi sent");
      repeat (12) @(posedge clock);
      #1;
    end
    gol = 1'b1;
    gov = 1'b1;
    @(posedge clock);
    #1 gov = 1'b0;
    repeat (2) @(posedge clock);
    #1 check(gout, 1'b1, "gpo level");
    $display("rate_and_gpio done");
  endtask

  // Watchdog sized well beyond the expected run of a few hundred cycles
  initial begin
    #50000;
    fail_count++;
    $display("ERROR at %0t: watchdog expired", $time);
    tally_and_finish();
  end

  initial begin
    strap_mode();
    channel_stagger();
    line_fault();
    rate_and_gpio();
    tally_and_finish();
  end
endmodule
`default_nettype wire

// >>> uc_model.sv
`timescale 1ns/10ps
`default_nettype none
module uc_model (
  input  wire logic       clock,
  output logic [7:0]      reg_addr,
  output logic            reg_wr,
  output logic [7:0]      reg_wdata,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  // Idle bus starts quiet
  initial begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_wdata = 8'h00;
    reg_rd    = 1'b0;
  end

  // One write strobe; released lines show inverted values so stale data never looks live
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    #1;
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(posedge clock);
    #1;
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask

  // One read strobe; the answer is awaited under a bounded count
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock);
    #1;
    reg_addr = a;
    reg_rd   = 1'b1;
    @(posedge clock);
    #1;
    reg_rd   = 1'b0;
    reg_addr = ~a;
    while (reg_rvalid !== 1'b1 && n < 4) begin
      @(posedge clock);
      #1;
      n++;
    end
    d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
  endtask
endmodule
`default_nettype wire
